/* File: rtl/acr_converter_ctrl.sv */
// Control, clock selection, successive approximation and result registers of the converter
`timescale 1ns/1ps
`include "acr_params.svh"

module acr_converter_ctrl
    import acr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    input  wire logic              frc_tick,
    input  wire logic              comp_in,
    output acr_analog_s            analog,
    output logic                   conv_complete
);

    // Limitations:
    //   comp_in and frc_tick are taken as synchronous to clock; an
    //   oscillator in another domain needs its tick synchronised outside.
    //   Reserved channel codes are stored as written; only route_valid
    //   drops, so the front end must ignore the routing while it is low.
    //   The result reads zero after reset; software must not rely on it
    //   before the first completion.
    //   The completion pulse lasts one cycle; the flag that latches it
    //   and the interrupt enable live outside this block.
    //   A start written in the same word as enable is dropped on purpose,
    //   since the front end has not powered up yet; enable first, then
    //   start in a later write.

    // The decoder compares the whole address with four-bit offsets, so narrower buses cannot be served
    if (ADDR_W < 4) begin : g_addr_check
        $error("acr_converter_ctrl: ADDR_W must be at least 4");
    end

    // Counts must leave room for the settle period and a nonzero recovery
    if (`ACR_CONV_TADS < 4'h2) begin : g_tad_check
        $error("acr_converter_ctrl: conversion count too small");
    end
    if (`ACR_ABORT_TADS == 2'h0) begin : g_rec_check
        $error("acr_converter_ctrl: recovery count must not be zero");
    end

    // Register and counter state; tad counts conversion periods, rec counts
    //   recovery periods after an early stop, div counts system clocks
    //   within one period. The sar and mask pair walks from bit 9 down.
    acr_ctrl_s   ctrl_q;
    acr_ctrl_s   ctrl_d;
    logic [2:0]  div_sel_q;
    logic [9:0]  result_q;
    logic [9:0]  sar_q;
    logic [9:0]  mask_q;
    logic [3:0]  tad_cnt_q;
    logic [1:0]  rec_cnt_q;
    logic [5:0]  div_cnt_q;
    acr_state_e  state_q;
    acr_state_e  state_d;
    logic        ready_q;
    logic        slverr_q;
    logic [31:0] rdata_q;
    logic        done_q;
    acr_analog_s analog_q;

    // Bus timing: the setup cycle captures the read view and arms ready,
    //   so every transfer completes in its first access cycle. Writes land
    //   on that access edge. A read therefore shows the state one cycle
    //   before the master samples it; a conversion that ends in that cycle
    //   is seen by the next poll.
    // Bus decode
    wire         setup_ph    = psel & ~penable;
    wire         access_wr   = psel & penable & ready_q & pwrite;
    wire         hit_main    = (paddr == ADDR_W'(`ACR_OFF_CTRL_MAIN));
    wire         hit_clk     = (paddr == ADDR_W'(`ACR_OFF_CLK_SEL));
    wire         hit_high    = (paddr == ADDR_W'(`ACR_OFF_RES_HIGH));
    wire         hit_low     = (paddr == ADDR_W'(`ACR_OFF_RES_LOW));
    wire         mapped      = hit_main | hit_clk | hit_high | hit_low;
    wire         wr_main     = access_wr & hit_main;
    wire         wr_clk      = access_wr & hit_clk;
    wire  [7:0]  wbyte       = pwdata[7:0];

    // Divider codes map to a power of two: the low two bits pick steps of
    //   four, the top bit doubles again; code x11 hands over to the
    //   oscillator tick, taken as already synchronous to the system clock.
    //   The divider is cleared on a start so the first period is whole;
    //   changing the code mid-conversion stretches or cuts one period only.
    // Conversion clock: divider over the system clock or the internal oscillator tick
    wire         use_frc     = (div_sel_q[1:0] == `ACR_DIV_FRC);
    wire  [2:0]  div_shift   = 3'({div_sel_q[1:0], 1'b1}) + 3'(div_sel_q[2]);
    wire  [5:0]  div_last    = 6'((7'h01 << div_shift) - 7'h01);
    wire         div_tick    = (div_cnt_q == div_last);
    wire         tad_tick    = use_frc ? frc_tick : div_tick;

    // Sequencer events
    wire         converting  = (state_q == ACR_CONVERT);
    wire         idle        = (state_q == ACR_IDLE);
    wire         start_req   = wr_main & wbyte[`ACR_BIT_GO] & ctrl_q.enable & idle;
    wire         sw_abort    = converting & wr_main & ~wbyte[`ACR_BIT_GO];
    wire         off_abort   = converting & ~ctrl_q.enable;
    wire         settle_tad  = (tad_cnt_q == 4'h0);
    wire         last_tad    = (tad_cnt_q == `ACR_CONV_TADS - 4'h1);
    wire         finish      = converting & tad_tick & last_tad & ~sw_abort & ~off_abort;
    wire  [9:0]  mask_next   = mask_q >> 1;

    // Per-bit decision: the trial bit drops out when the held input is below the code
    logic [9:0]  sar_kept;
    for (genvar b = 0; b < $bits(sar_q); b++) begin : g_sar_bit
        assign sar_kept[b] = mask_q[b] ? (sar_q[b] & comp_in) : sar_q[b];
    end

    // Channel routing: pins 0-7 and the three internal references
    wire  [3:0]  chan        = ctrl_d.channel; // Same cycle as the routed channel
    wire         chan_pin    = (chan <= `ACR_CHAN_LAST_PIN);
    wire         chan_ref    = (chan == `ACR_CHAN_CMP_REF) | (chan == `ACR_CHAN_REF_0V6) |
                               (chan == `ACR_CHAN_REF_1V2);

    // Read view per offset:
    //   main control  justify, reference, channel, start/busy, enable
    //   clock select  divider field in 6:4, other bits zero
    //   result high   left: bits 9-2; right: bits 9-8 in 1:0
    //   result low    left: bits 1-0 in 7:6; right: bits 7-0
    //   reserved result bits read zero rather than stale data
    // Result byte layouts for the two justifications
    wire  [7:0]  res_high    = ctrl_q.justify_right ? {6'h00, result_q[9:8]} : result_q[9:2];
    wire  [7:0]  res_low     = ctrl_q.justify_right ? result_q[7:0] : {result_q[1:0], 6'h00};
    wire  [7:0]  clk_rd      = {1'b0, div_sel_q, 4'h0};
    wire  [7:0]  rd_byte     = hit_main ? ctrl_q : hit_clk ? clk_rd : hit_high ? res_high :
                               hit_low ? res_low : 8'h00;

    // Next value of the main control register
    //   While converting, writing zero to start aborts and writing one
    //   keeps the conversion running. Completion and power-off both clear
    //   the start bit, and they win over a write in the same cycle.
    //   A start outside idle, recovery included, is dropped.
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_main) begin
            ctrl_d.justify_right = wbyte[`ACR_BIT_JUSTIFY];
            ctrl_d.ref_external  = wbyte[`ACR_BIT_REF];
            ctrl_d.channel       = wbyte[`ACR_CHAN_HI:`ACR_CHAN_LO];
            ctrl_d.enable        = wbyte[`ACR_BIT_EN];
            ctrl_d.go            = converting ? wbyte[`ACR_BIT_GO] : start_req;
        end
        if (finish | off_abort) begin
            ctrl_d.go = 1'b0;
        end
    end

    // Sequencer next state
    // Idle: hold switch closed while enabled, the capacitor tracks the pin
    // Convert: first period settles, the next ten decide bits 9 down to 0
    // Recover: after an early stop the switch stays open for two periods
    // A start is only honoured from idle, so a start in recovery is dropped
    // Clearing enable mid-conversion takes the same recovery path as a stop
    // The result only ever loads from the convert state on its last period
    // Recovery counts ticks of the chosen conversion clock; the divider is not restarted, so the first may be short
    // No state holds the hold switch closed while the converter is off
    always_comb begin
        state_d = state_q;
        case (state_q)
            ACR_IDLE: begin
                if (start_req) begin
                    state_d = ACR_CONVERT;
                end
            end
            ACR_CONVERT: begin
                if (sw_abort | off_abort) begin
                    state_d = ACR_RECOVER;
                end else if (finish) begin
                    state_d = ACR_IDLE;
                end
            end
            ACR_RECOVER: begin
                if (tad_tick & (rec_cnt_q == `ACR_ABORT_TADS - 2'h1)) begin
                    state_d = ACR_IDLE;
                end
            end
            default: begin
                state_d = ACR_IDLE;
            end
        endcase
    end

    // Main control register
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q <= `ACR_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Sequencer state
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= ACR_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Clock select register; only the divider field is stored, the rest reads zero
    always_ff @(posedge clock) begin
        if (rst) begin
            div_sel_q <= `ACR_DIV_RESET;
        end else if (wr_clk) begin
            div_sel_q <= wbyte[`ACR_DIV_HI:`ACR_DIV_LO];
        end
    end

    // Divider restarts with each conversion so the first period is whole
    always_ff @(posedge clock) begin
        if (rst | start_req | div_tick) begin
            div_cnt_q <= 6'h00;
        end else begin
            div_cnt_q <= div_cnt_q + 6'h01;
        end
    end

    // Recovery period count after an early stop; it rests at zero outside
    //   recovery so each abort counts two ticks, the first possibly a partial period
    always_ff @(posedge clock) begin
        if (rst | (state_q != ACR_RECOVER)) begin
            rec_cnt_q <= 2'h0;
        end else if (tad_tick) begin
            rec_cnt_q <= rec_cnt_q + 2'h1;
        end
    end

    // Conversion period count from the start write
    always_ff @(posedge clock) begin
        if (rst | start_req) begin
            tad_cnt_q <= 4'h0;
        end else if (converting & tad_tick) begin
            tad_cnt_q <= tad_cnt_q + 4'h1;
        end
    end

    // Successive approximation: one settle period, then one bit per period
    always_ff @(posedge clock) begin
        if (rst | start_req) begin
            sar_q  <= `ACR_SAR_FIRST;
            mask_q <= `ACR_SAR_FIRST;
        end else if (converting & tad_tick & ~settle_tad) begin
            sar_q  <= sar_kept | mask_next;
            mask_q <= mask_next;
        end
    end

    // Completion pulse for the flag logic outside
    always_ff @(posedge clock) begin
        if (rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= finish;
        end
    end

    // Result loads as one word so both bytes always match; aborts leave it alone
    always_ff @(posedge clock) begin
        if (rst) begin
            result_q <= `ACR_RES_RESET;
        end else if (finish) begin
            result_q <= sar_kept;
        end
    end

    // Front end fields: powered follows enable, ref_external picks the
    //   positive reference, channel and route_valid steer the input mux,
    //   sample_closed closes the hold switch, dac_code is the trial code.
    //   All are registered so the front end sees no decode glitches.
    wire         afe_route   = chan_pin | chan_ref;
    wire         afe_sample  = ctrl_d.enable & (state_d == ACR_IDLE);

    // Analog front end controls; the hold switch simply reopens, it never dumps charge
    always_ff @(posedge clock) begin
        if (rst) begin
            analog_q <= '0;
        end else begin
            analog_q.powered       <= ctrl_d.enable;
            analog_q.ref_external  <= ctrl_d.ref_external;
            analog_q.channel       <= ctrl_d.channel;
            analog_q.route_valid   <= afe_route;
            analog_q.sample_closed <= afe_sample;
            analog_q.dac_code      <= sar_q;
        end
    end

    // Bus answer is prepared in the setup cycle, giving zero wait states
    always_ff @(posedge clock) begin
        if (rst) begin
            ready_q  <= 1'b0;
            slverr_q <= 1'b0;
        end else begin
            ready_q  <= setup_ph;
            slverr_q <= setup_ph & ~mapped;
        end
    end

    // Read data is zero for writes and unmapped reads, so no stale value shows
    always_ff @(posedge clock) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (setup_ph) begin
            rdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
    end

    // Every output is a flop: the bus answer, the front end controls and
    //   the completion pulse. Nothing combinational leaves the block, so
    //   the far side sees clean levels a full cycle after each decision.
    assign pready        = ready_q;
    assign pslverr       = slverr_q;
    assign prdata        = rdata_q;
    assign analog        = analog_q;
    assign conv_complete = done_q;

endmodule : acr_converter_ctrl

/* File: rtl/acr_params.svh */
// Register map, field positions, reset values and timing counts of the converter control block
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// Register byte offsets on the bus, one aligned word each
`define ACR_OFF_CTRL_MAIN    4'h0
`define ACR_OFF_CLK_SEL      4'h4
`define ACR_OFF_RES_HIGH     4'h8
`define ACR_OFF_RES_LOW      4'hc

// Main control register fields
`define ACR_BIT_JUSTIFY      7
`define ACR_BIT_REF          6
`define ACR_CHAN_HI          5
`define ACR_CHAN_LO          2
`define ACR_BIT_GO           1
`define ACR_BIT_EN           0
`define ACR_CTRL_RESET       8'h00

// Clock select register field
`define ACR_DIV_HI           6
`define ACR_DIV_LO           4
`define ACR_DIV_RESET        3'h0
`define ACR_DIV_FRC          2'h3

// Channel codes that route something
`define ACR_CHAN_LAST_PIN    4'h7
`define ACR_CHAN_CMP_REF     4'hc
`define ACR_CHAN_REF_0V6     4'hd
`define ACR_CHAN_REF_1V2     4'he

// Conversion timing in conversion clock periods, then result reset value and first trial code
`define ACR_CONV_TADS        4'hb
`define ACR_ABORT_TADS       2'h2
`define ACR_RES_RESET        10'h000
`define ACR_SAR_FIRST        10'h200

`endif

/* File: rtl/acr_pkg.sv */
// Types shared by the converter control block
package acr_pkg;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ACR_IDLE    = 2'b00,
        ACR_CONVERT = 2'b01,
        ACR_RECOVER = 2'b10
    } acr_state_e;

    // Software view of the main control register
    typedef struct packed {
        logic       justify_right;
        logic       ref_external;
        logic [3:0] channel;
        logic       go;
        logic       enable;
    } acr_ctrl_s;

    // Controls handed to the analog front end
    typedef struct packed {
        logic       powered;
        logic       ref_external;
        logic [3:0] channel;
        logic       route_valid;
        logic       sample_closed;
        logic [9:0] dac_code;
    } acr_analog_s;

endpackage : acr_pkg

/* File: test/acr_analog_model.sv */
// Analog front end: hold capacitor, comparator and internal oscillator
`timescale 1ns/1ps
module acr_analog_model
    import acr_pkg::*;
#(
    parameter int FRC_DIV = 250
) (
    input wire logic       clock,
    input acr_analog_s     analog,
    input wire logic [9:0] level,
    output logic           comp_in,
    output logic           frc_tick
);
    logic [9:0] held_q = 10'h0;
    logic       tog_q = 1'b0;
    int         cnt_q = 0;
    // Charge kept between conversions, only tracks pin while switch closed
    always @(posedge clock) begin
        if (analog.sample_closed) held_q <= level;
        tog_q <= ~tog_q;
        cnt_q <= (cnt_q == FRC_DIV - 1) ? 0 : cnt_q + 1;
        frc_tick <= (cnt_q == FRC_DIV - 1);
    end
    // Unpowered comparator gives no stable decision
    assign comp_in = analog.powered ? (held_q >= analog.dac_code) : tog_q;
endmodule : acr_analog_model

/* File: test/acr_properties.sv */
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module acr_properties
    import acr_pkg::*;
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input acr_analog_s      analog,
    input wire logic        conv_complete
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    // Zero-wait bus answer, one cycle wide
    ready_after_setup_a: assert property (
        psel && !penable |=> pready) else $error("no ready after setup");
    ready_cause_a: assert property (
        pready |-> $past(psel) && !$past(penable)) else $error("ready without setup");
    ready_pulse_a: assert property (
        pready |=> !pready) else $error("ready longer than one cycle");
    upper_zero_a: assert property (
        pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    unmapped_data_a: assert property (
        pslverr |-> pready && prdata == 32'h0) else $error("bad unmapped answer");
    done_pulse_a: assert property (
        conv_complete |=> !conv_complete) else $error("done flag not a pulse");
    hold_powered_a: assert property (
        analog.sample_closed |-> analog.powered) else $error("sampling while off");
    route_decode_a: assert property (
        analog.powered && $stable(analog.channel) |->
        analog.route_valid == !(analog.channel inside {4'h8, 4'h9, 4'ha, 4'hb, 4'hf}))
        else $error("route valid wrong");
endmodule : acr_properties

bind acr_converter_ctrl acr_properties u_props (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .analog(analog), .conv_complete(conv_complete));

/* File: test/tb.sv */
// Self-checking bench: bus access, conversions on every clock code, abort, routing
`timescale 1ns/1ps
module tb;
    import acr_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, comp_in, frc_tick, conv_complete;
    logic [9:0]  level = 10'h0;
    logic [9:0]  hold;
    acr_analog_s analog;
    int          err_total = 0;
    int          samples_checked = 0;
    logic [7:0]  q;
    logic        e;
    int          divs [8] = '{2, 8, 32, 0, 4, 16, 64, 0};

    acr_converter_ctrl u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .frc_tick(frc_tick), .comp_in(comp_in), .analog(analog), .conv_complete(conv_complete));
    acr_analog_model u_afe (.clock(clock), .analog(analog), .level(level), .comp_in(comp_in),
        .frc_tick(frc_tick));

    // Free-running system clock
    initial forever #4 clock = ~clock;

    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
        samples_checked++;
        if (s !== x) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, x, s);
        end
    endtask : chk

    task automatic give_verdict();
        if (err_total == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // Idle edge at the end so back-to-back calls never drive psel twice at once
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] rd,
                       output logic er);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata[7:0];
        er = pslverr;
        chk("bus ready", 8'(pready), 8'h01);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    function automatic logic [7:0] exp_hi(logic j, logic [9:0] r);
        return j ? {6'h0, r[9:8]} : r[9:2];
    endfunction : exp_hi

    function automatic logic [7:0] exp_lo(logic j, logic [9:0] r);
        return j ? r[7:0] : {r[1:0], 6'h0};
    endfunction : exp_lo

    // Polled conversion; n counts cycles from the start write to the done pulse
    task automatic conv(input logic [2:0] dv, input logic j, input int nd);
        int n;
        level <= 10'($urandom_range(1023));
        apb(1'b1, 12'h4, {1'b0, dv, 4'h0}, q, e);
        apb(1'b1, 12'h0, {j, 7'h01}, q, e);
        repeat (20) @(posedge clock);
        apb(1'b1, 12'h0, {j, 7'h03}, q, e);
        n = 1;
        while (conv_complete !== 1'b1 && n < 4000) begin
            @(posedge clock);
            n++;
        end
        chk("done pulse", 8'(conv_complete), 8'h01);
        if (nd > 0) chk("conv time", 8'(n >= 11 * nd && n <= 11 * nd + 3), 8'h01);
        n = 0;
        do begin
            apb(1'b0, 12'h0, 8'h0, q, e);
            n++;
        end while (q[1] !== 1'b0 && n < 100);
        chk("start bit", q, {j, 7'h01});
        apb(1'b0, 12'h8, 8'h0, q, e);
        chk("result high", q, exp_hi(j, level));
        apb(1'b0, 12'hc, 8'h0, q, e);
        chk("result low", q, exp_lo(j, level));
    endtask : conv

    // Main sequence
    initial begin
        void'($urandom(26429));
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        apb(1'b0, 12'h0, 8'h0, q, e);
        chk("main reset", q, 8'h00);
        apb(1'b1, 12'h4, 8'hff, q, e);
        apb(1'b0, 12'h4, 8'h0, q, e);
        chk("clock select", q, 8'h70);
        apb(1'b1, 12'h8, 8'hff, q, e);
        apb(1'b0, 12'h8, 8'h0, q, e);
        chk("result read only", q, 8'h00);
        apb(1'b0, 12'h10, 8'h0, q, e);
        chk("unmapped", 8'(e), 8'h01);
        apb(1'b1, 12'h10, 8'hff, q, e);
        chk("unmapped write", 8'(e), 8'h01);
        apb(1'b1, 12'h0, 8'h03, q, e);
        apb(1'b0, 12'h0, 8'h0, q, e);
        chk("start with enable", q, 8'h01);
        for (int i = 0; i < 8; i++) conv(3'(i), 1'(i), divs[i]);
        hold = level;
        apb(1'b1, 12'h4, 8'h60, q, e);
        level <= ~level;
        repeat (20) @(posedge clock);
        apb(1'b1, 12'h0, 8'h83, q, e);
        apb(1'b0, 12'h0, 8'h0, q, e);
        chk("busy", q, 8'h83);
        repeat (97) @(posedge clock);
        apb(1'b1, 12'h0, 8'h81, q, e);
        chk("hold after abort", 8'(analog.sample_closed), 8'h00);
        repeat (200) @(posedge clock);
        chk("reacquire", 8'(analog.sample_closed), 8'h01);
        apb(1'b0, 12'hc, 8'h0, q, e);
        chk("kept result", q, exp_lo(1'b1, hold));
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, 12'h0, {1'b0, 1'(c), 4'(c), 2'b01}, q, e);
            repeat (2) @(posedge clock);
            chk("channel", {4'h0, analog.channel}, 8'(c));
            chk("route", 8'(analog.route_valid), 8'(!(c inside {[8:11], 15})));
            chk("reference", 8'(analog.ref_external), 8'(c & 1));
            chk("powered", 8'(analog.powered), 8'h01);
        end
        apb(1'b1, 12'h0, 8'h00, q, e);
        repeat (2) @(posedge clock);
        chk("off", {7'h0, analog.powered | analog.sample_closed}, 8'h00);
        give_verdict();
    end

    // Watchdog against a run that never reaches its verdict
    initial begin
        repeat (50000) @(posedge clock);
        err_total++;
        give_verdict();
    end
endmodule : tb
